/* File: rtl/tmi_core.sv */
// instruction decode and execute core of the 4-bit tuner controller
`default_nettype none
module tmi_core
  import tmi_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  // program memory
  output logic [PC_W-1:0]         progAddr,
  input  wire logic [15:0]        progWord,
  // status register 2 inputs from the pins
  input  wire logic [NIB_W-1:0]   stat2Pins,
  // block outputs
  output logic [NIB_W-1:0]        stat1Out,
  output logic [PLL_W-1:0]        pllDivider,
  output logic [SEG_W-1:0]        segmentData,
  output logic [NIB_W-1:0]        portFDir,
  output logic                    intEnable,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest
);

  typedef enum logic [0:0] {RUN_HALT, RUN_GO} tmi_run_t;

  // 4-bit add, returns carry in bit 4
  function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
                                      input logic ci);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction

  // 4-bit subtract, returns borrow in bit 4
  function automatic logic [4:0] sub5(input logic [3:0] a, input logic [3:0] b,
                                      input logic bi);
    sub5 = {1'b0, a} - {1'b0, b} - {4'h0, bi};
  endfunction

  // 7-segment pattern, bit order gfedcba
  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      4'hA: seg7 = 7'h77;
      4'hB: seg7 = 7'h7C;
      4'hC: seg7 = 7'h39;
      4'hD: seg7 = 7'h5E;
      4'hE: seg7 = 7'h79;
      default: seg7 = 7'h71;
    endcase
  endfunction

  logic [NIB_W-1:0]  dataMem [0:(1<<MEM_AW)-1];
  logic [PC_W-1:0]   stack_r [0:STACK_D-1];
  logic [1:0]        sp_r;
  tmi_run_t          run_r;
  logic [PC_W-1:0]   pc_r;
  logic              skip_r;
  tmi_flags_t        flags_r;
  logic [NIB_W-1:0]  stat2Meta_r;
  logic [NIB_W-1:0]  stat2_r;
  logic [PLL_W-1:0]  pll_r;
  logic [SEG_W-1:0]  seg_r;
  logic [NIB_W-1:0]  portF_r;
  logic              intEn_r;
  logic              ack_r;
  logic [31:0]       rdata_r;

  tmi_instr_t        ins;
  logic              isBranch;
  logic              exec;
  logic [MEM_AW-1:0] mAddr;
  logic [MEM_AW-1:0] rAddr;
  logic [MEM_AW-1:0] indAddr;
  logic [NIB_W-1:0]  memM;
  logic [NIB_W-1:0]  memR;
  logic [NIB_W-1:0]  memInd;
  logic [PLL_W-1:0]  pllGather;
  logic [NIB_W-1:0]  maskedM;
  logic [NIB_W-1:0]  maskedS2;
  logic [4:0]        alu;
  logic              aluUsed;
  logic              wrEn;
  logic [MEM_AW-1:0] wrAddr;
  logic [NIB_W-1:0]  wrData;
  logic              skipNow;
  logic              busAcc;
  logic              busWr;

  // operand addressing
  assign ins      = progWord;
  assign isBranch = (progWord[15:13] == BR_PREFIX);
  assign exec     = (run_r == RUN_GO) && !skip_r;
  assign mAddr    = {flags_r.bank, ins.rowAddressHigh, ins.colAddress};
  assign rAddr    = {flags_r.bank, 2'h0, ins.low};
  assign memM     = dataMem[mAddr];
  assign memR     = dataMem[rAddr];
  assign indAddr  = {flags_r.bank, ins.rowAddressHigh, memR};
  assign memInd   = dataMem[indAddr];
  assign maskedM  = memM & ins.low;
  assign maskedS2 = stat2_r & ins.low;

  // four nibbles of a memory quad feed the divider, low nibble first
  always_comb begin
    pllGather = '0;
    for (int i = 0; i < 4; i++) begin
      pllGather[i*4 +: 4] = dataMem[{mAddr[MEM_AW-1:2], 2'(i)}];
    end
  end

  // execute decode: arithmetic, memory write port and skip condition
  always_comb begin
    alu     = 5'h00;
    aluUsed = 1'b0;
    wrEn    = 1'b0;
    wrAddr  = rAddr;
    wrData  = 4'h0;
    skipNow = 1'b0;
    if (exec && !isBranch) begin
      case (ins.op)
        OP_SUM_MEM, OP_SUM_MEM_SKIP_CARRY: begin
          alu = add5(memR, memM, 1'b0);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_SUM_MEM_SKIP_CARRY) && alu[4];
        end
        OP_SUM_MEM_WITH_CARRY, OP_SUM_CARRY_THEN_SKIP: begin
          alu = add5(memR, memM, flags_r.carry);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_SUM_CARRY_THEN_SKIP) && alu[4];
        end
        OP_SUM_IMM_INTO_MEM, OP_SUM_IMM_SKIP_CARRY: begin
          alu = add5(memM, ins.low, 1'b0);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_SUM_IMM_SKIP_CARRY) && alu[4];
        end
        OP_SUM_IMM_WITH_CARRY, OP_SUM_IMM_CARRY_SKIP: begin
          alu = add5(memM, ins.low, flags_r.carry);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_SUM_IMM_CARRY_SKIP) && alu[4];
        end
        OP_DIFF_MEM_FROM_REG, OP_DIFF_MEM_SKIP_BORROW: begin
          alu = sub5(memR, memM, 1'b0);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_DIFF_MEM_SKIP_BORROW) && alu[4];
        end
        OP_DIFF_WITH_BORROW, OP_DIFF_WITH_BORROW_SKIP: begin
          alu = sub5(memR, memM, flags_r.carry);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_DIFF_WITH_BORROW_SKIP) && alu[4];
        end
        OP_DIFF_IMM, OP_DIFF_IMM_SKIP_BORROW: begin
          alu = sub5(memM, ins.low, 1'b0);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_DIFF_IMM_SKIP_BORROW) && alu[4];
        end
        OP_DIFF_IMM_WITH_BORROW, OP_DIFF_IMM_BORROW_SKIP: begin
          alu = sub5(memM, ins.low, flags_r.carry);
          aluUsed = 1'b1;
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = alu[3:0];
          skipNow = (ins.op == OP_DIFF_IMM_BORROW_SKIP) && alu[4];
        end
        OP_COMPARE_REG_EQ_MEM: skipNow = (memR == memM);
        OP_COMPARE_REG_GE_MEM: skipNow = (memR >= memM);
        OP_COMPARE_MEM_EQ_IMM: skipNow = (memM == ins.low);
        OP_COMPARE_MEM_GE_IMM: skipNow = (memM >= ins.low);
        OP_AND_IMM, OP_OR_IMM: begin
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = (ins.op == OP_AND_IMM) ? (memM & ins.low) : (memM | ins.low);
        end
        OP_XOR_REG_WITH_MEM: begin
          wrEn = 1'b1;
          wrData = memR ^ memM;
        end
        OP_READ_MEM_TO_REG: begin
          wrEn = 1'b1;
          wrData = memM;
        end
        OP_WRITE_REG_TO_MEM: begin
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = memR;
        end
        OP_PUT_IMM_TO_MEM: begin
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = ins.low;
        end
        OP_INDIRECT_DEST_MOVE: begin
          wrEn = 1'b1;
          wrAddr = indAddr;
          wrData = memM;
        end
        OP_INDIRECT_SRC_MOVE: begin
          wrEn = 1'b1;
          wrAddr = mAddr;
          wrData = memInd;
        end
        OP_CHECK_MEM_BITS_ONE:  skipNow = (maskedM == ins.low);
        OP_CHECK_MEM_BITS_ZERO: skipNow = (maskedM == 4'h0);
        OP_FLAGS_ALL_ONE_SKIP:  skipNow = (maskedS2 == ins.low);
        OP_FLAGS_ALL_ZERO_SKIP: skipNow = (maskedS2 == 4'h0);
        default: ;
      endcase
    end
  end

  // single write port; bus writes reach memory only while halted, bus reads at any time
  assign busAcc = avs_read || avs_write;
  assign busWr  = avs_write && ack_r;
  always_ff @(posedge clk) begin
    if (wrEn) begin
      dataMem[wrAddr] <= wrData;
    end else if (busWr && run_r == RUN_HALT && avs_address >= OFS_MEM) begin
      dataMem[avs_address[9:2]] <= avs_writedata[3:0];
    end
  end

  // run state, program counter and return stack
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= RUN_HALT;
      pc_r  <= PC_RST;
      sp_r  <= 2'h0;
      for (int i = 0; i < STACK_D; i++) stack_r[i] <= PC_RST;
    end else begin
      case (run_r)
        RUN_HALT: begin
          if (busWr && avs_address == OFS_PC) pc_r <= avs_writedata[PC_W-1:0];
          if (busWr && avs_address == OFS_CTRL && avs_writedata[CTRL_RUN_BIT]) run_r <= RUN_GO;
        end
        RUN_GO: begin
          if (busWr && avs_address == OFS_CTRL && !avs_writedata[CTRL_RUN_BIT]) run_r <= RUN_HALT;
          if (!exec) begin
            pc_r <= pc_r + 12'h001;
          end else if (isBranch) begin
            pc_r <= progWord[PC_W-1:0];
            if (progWord[12]) begin
              stack_r[sp_r] <= pc_r + 12'h001;
              sp_r <= sp_r + 2'h1; // four deep, oldest entry overwritten
            end
          end else if (ins.op == OP_RETURN_SUB || ins.op == OP_RETURN_INT) begin
            pc_r <= stack_r[sp_r - 2'h1];
            sp_r <= sp_r - 2'h1;
          end else begin
            pc_r <= pc_r + 12'h001;
          end
        end
        default: run_r <= RUN_HALT;
      endcase
    end
  end

  // skip flag: a satisfied test suppresses exactly one instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) skip_r <= 1'b0;
    else if (run_r == RUN_GO) skip_r <= skipNow;
  end

  // carry, bank and status register 1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= '{carry: 1'b0, bank: 2'h0, stat1: STAT1_RST};
    end else if (exec && !isBranch) begin
      if (aluUsed) flags_r.carry <= alu[4];
      case (ins.op)
        OP_SET_FLAG_BITS:   flags_r.stat1 <= flags_r.stat1 | ins.low;
        OP_CLEAR_FLAG_BITS: flags_r.stat1 <= flags_r.stat1 & ~ins.low;
        OP_BANK_SELECT:     flags_r.bank <= ins.low[1:0];
        default: ;
      endcase
    end
  end

  // status register 2 pins come from outside, two stages first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat2Meta_r <= 4'h0;
      stat2_r     <= 4'h0;
    end else begin
      stat2Meta_r <= stat2Pins;
      stat2_r     <= stat2Meta_r;
    end
  end

  // peripheral latches: divider, segments, port F direction, interrupt enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_r   <= '0;
      seg_r   <= '0;            // blank display
      portF_r <= PORTF_RST;
      intEn_r <= 1'b0;
    end else if (exec && !isBranch) begin
      case (ins.op)
        OP_PLL_LOAD:               pll_r <= pllGather;
        OP_SEGMENT_DIRECT_WRITE:   seg_r[ins.low[1:0]*7 +: 4] <= memM;
        OP_SEGMENT_DECODED_WRITE:  seg_r[ins.low[1:0]*7 +: 7] <= seg7(memM);
        OP_PORT_F_DIRECTION_LATCH: portF_r <= ins.low;
        OP_RETURN_INT:             intEn_r <= 1'b1;
        default: ;
      endcase
    end
  end

  // bus answer: one wait cycle, read data captured in it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= busAcc && !ack_r;
      if (avs_read && !ack_r) begin
        rdata_r <= 32'h0000_0000;
        if (avs_address >= OFS_MEM) rdata_r[3:0] <= dataMem[avs_address[9:2]];
        else case (avs_address)
          OFS_CTRL:  rdata_r[CTRL_RUN_BIT] <= (run_r == RUN_GO);
          OFS_PC:    rdata_r[PC_W-1:0] <= pc_r;
          OFS_FLAGS: begin
            rdata_r[FLG_CARRY_BIT] <= flags_r.carry;
            rdata_r[FLG_SKIP_BIT]  <= skip_r;
            rdata_r[FLG_INTEN_BIT] <= intEn_r;
            rdata_r[FLG_BANK_LSB +: 2]  <= flags_r.bank;
            rdata_r[FLG_STAT1_LSB +: 4] <= flags_r.stat1;
            rdata_r[FLG_STAT2_LSB +: 4] <= stat2_r;
            rdata_r[FLG_SP_LSB +: 2]    <= sp_r;
          end
          OFS_PLL:   rdata_r[PLL_W-1:0] <= pll_r;
          OFS_SEG:   rdata_r[SEG_W-1:0] <= seg_r;
          OFS_PORTF: rdata_r[3:0] <= portF_r;
          default:   rdata_r <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  assign avs_waitrequest = !ack_r;
  assign avs_readdata    = rdata_r;
  assign progAddr        = pc_r;
  assign stat1Out        = flags_r.stat1;
  assign pllDivider      = pll_r;
  assign segmentData     = seg_r;
  assign portFDir        = portF_r;
  assign intEnable       = intEn_r;

endmodule
`default_nettype wire

/* File: rtl/tmi_pkg.sv */
// package: constants, op-codes and carriers of the tuner instruction core
`default_nettype none
package tmi_pkg;
  // data path widths
  localparam int PC_W      = 12;
  localparam int NIB_W     = 4;
  localparam int MEM_AW    = 8;
  localparam int STACK_D   = 4;
  localparam int SEG_DIGITS = 4;
  localparam int SEG_W     = 7 * SEG_DIGITS;
  localparam int PLL_W     = 16;
  localparam int BUS_AW    = 11;

  // register window byte offsets
  localparam logic [10:0] OFS_CTRL   = 11'h000;
  localparam logic [10:0] OFS_PC     = 11'h004;
  localparam logic [10:0] OFS_FLAGS  = 11'h008;
  localparam logic [10:0] OFS_PLL    = 11'h00C;
  localparam logic [10:0] OFS_SEG    = 11'h010;
  localparam logic [10:0] OFS_PORTF  = 11'h014;
  localparam logic [10:0] OFS_MEM    = 11'h400;  // 256 words, one nibble each

  // field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int FLG_CARRY_BIT  = 0;
  localparam int FLG_SKIP_BIT   = 1;
  localparam int FLG_INTEN_BIT  = 2;
  localparam int FLG_BANK_LSB   = 4;
  localparam int FLG_STAT1_LSB  = 8;
  localparam int FLG_STAT2_LSB  = 12;
  localparam int FLG_SP_LSB     = 16;

  // reset values
  localparam logic [11:0] PC_RST    = 12'h000;
  localparam logic [3:0]  PORTF_RST = 4'h0;   // all pins inputs
  localparam logic [3:0]  STAT1_RST = 4'h0;

  // absolute branch space: top three bits 111, bit 12 picks call
  localparam logic [2:0] BR_PREFIX = 3'h7;

  // op-codes in bits 15:10
  localparam logic [5:0] OP_NOP                    = 6'h00;
  localparam logic [5:0] OP_SUM_MEM                = 6'h01;
  localparam logic [5:0] OP_SUM_MEM_SKIP_CARRY     = 6'h02;
  localparam logic [5:0] OP_SUM_MEM_WITH_CARRY     = 6'h03;
  localparam logic [5:0] OP_SUM_CARRY_THEN_SKIP    = 6'h04;
  localparam logic [5:0] OP_SUM_IMM_INTO_MEM       = 6'h05;
  localparam logic [5:0] OP_SUM_IMM_SKIP_CARRY     = 6'h06;
  localparam logic [5:0] OP_SUM_IMM_WITH_CARRY     = 6'h07;
  localparam logic [5:0] OP_SUM_IMM_CARRY_SKIP     = 6'h08;
  localparam logic [5:0] OP_DIFF_MEM_FROM_REG      = 6'h09;
  localparam logic [5:0] OP_DIFF_MEM_SKIP_BORROW   = 6'h0A;
  localparam logic [5:0] OP_DIFF_WITH_BORROW       = 6'h0B;
  localparam logic [5:0] OP_DIFF_WITH_BORROW_SKIP  = 6'h0C;
  localparam logic [5:0] OP_DIFF_IMM               = 6'h0D;
  localparam logic [5:0] OP_DIFF_IMM_SKIP_BORROW   = 6'h0E;
  localparam logic [5:0] OP_DIFF_IMM_WITH_BORROW   = 6'h0F;
  localparam logic [5:0] OP_DIFF_IMM_BORROW_SKIP   = 6'h10;
  localparam logic [5:0] OP_COMPARE_REG_EQ_MEM     = 6'h11;
  localparam logic [5:0] OP_COMPARE_REG_GE_MEM     = 6'h12;
  localparam logic [5:0] OP_COMPARE_MEM_EQ_IMM     = 6'h13;
  localparam logic [5:0] OP_COMPARE_MEM_GE_IMM     = 6'h14;
  localparam logic [5:0] OP_AND_IMM                = 6'h15;
  localparam logic [5:0] OP_OR_IMM                 = 6'h16;
  localparam logic [5:0] OP_XOR_REG_WITH_MEM       = 6'h17;
  localparam logic [5:0] OP_READ_MEM_TO_REG        = 6'h18;
  localparam logic [5:0] OP_WRITE_REG_TO_MEM       = 6'h19;
  localparam logic [5:0] OP_PUT_IMM_TO_MEM         = 6'h1A;
  localparam logic [5:0] OP_INDIRECT_DEST_MOVE     = 6'h1B;
  localparam logic [5:0] OP_INDIRECT_SRC_MOVE      = 6'h1C;
  localparam logic [5:0] OP_PLL_LOAD               = 6'h1D;
  localparam logic [5:0] OP_CHECK_MEM_BITS_ONE     = 6'h1E;
  localparam logic [5:0] OP_CHECK_MEM_BITS_ZERO    = 6'h1F;
  localparam logic [5:0] OP_SET_FLAG_BITS          = 6'h20;
  localparam logic [5:0] OP_CLEAR_FLAG_BITS        = 6'h21;
  localparam logic [5:0] OP_FLAGS_ALL_ONE_SKIP     = 6'h22;
  localparam logic [5:0] OP_FLAGS_ALL_ZERO_SKIP    = 6'h23;
  localparam logic [5:0] OP_BANK_SELECT            = 6'h24;
  localparam logic [5:0] OP_SEGMENT_DIRECT_WRITE   = 6'h25;
  localparam logic [5:0] OP_SEGMENT_DECODED_WRITE  = 6'h26;
  localparam logic [5:0] OP_PORT_F_DIRECTION_LATCH = 6'h27;
  localparam logic [5:0] OP_RETURN_SUB             = 6'h28;
  localparam logic [5:0] OP_RETURN_INT             = 6'h29;

  // instruction word outside the branch space
  typedef struct packed {
    logic [5:0] op;
    logic [1:0] rowAddressHigh;
    logic [3:0] colAddress;
    logic [3:0] low;        // index_reg_num, immediate or bit mask
  } tmi_instr_t;

  // architectural flags carried together
  typedef struct packed {
    logic       carry;
    logic [1:0] bank;
    logic [3:0] stat1;
  } tmi_flags_t;
endpackage
`default_nettype wire

/* File: test/testbench.sv */
// testbench: rom program run on bus-loaded data against the instruction core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tmi_pkg::*;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [PC_W-1:0]      progAddr;
  logic [15:0]          progWord;
  logic [NIB_W-1:0]     stat2Pins = 4'h6;
  logic [NIB_W-1:0]     stat1Out;
  logic [PLL_W-1:0]     pllDivider;
  logic [SEG_W-1:0]     segmentData;
  logic [NIB_W-1:0]     portFDir;
  logic                 intEnable;
  logic [BUS_AW-1:0]    avs_address = '0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = '0;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [31:0]          rd;
  logic [15:0]          rom [0:4095];
  logic [3:0]           memIn [12] = '{4'h0, 4'h9, 4'h8, 4'h0, 4'h7, 4'h0, 4'h3, 4'h0,
                                       4'h0, 4'hC, 4'h0, 4'h0};
  logic [3:0]           memExp [12] = '{4'h0, 4'h9, 4'h1, 4'h0, 4'h0, 4'h2, 4'hA, 4'h0,
                                        4'h0, 4'h5, 4'h0, 4'h0};
  logic [3:0]           memExp2 [15] = '{4'h5, 4'h9, 4'hB, 4'h0, 4'h0, 4'hF, 4'h3, 4'h2,
                                         4'h0, 4'h9, 4'h5, 4'h5, 4'hD, 4'h9, 4'h9};
  int                   pa;
  int                   failures = 0;
  int                   total_checks = 0;
  // combinational program rom, row bits always zero
  assign progWord = rom[progAddr];
  always #5 clk = ~clk;
  tmi_core DUT (.clk, .nrst, .progAddr, .progWord, .stat2Pins, .stat1Out, .pllDivider,
    .segmentData, .portFDir, .intEnable, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  function automatic logic [15:0] iw(logic [5:0] o, logic [3:0] c, logic [3:0] l);
    return {o, 2'b00, c, l};
  endfunction
  // place one instruction at the next program slot
  task automatic put(input logic [5:0] o, input logic [3:0] c, input logic [3:0] l);
    rom[pa] = iw(o, c, l);
    pa++;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // one avalon transfer; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    results;
  end
  initial begin
    // unused slots drop a marker into nibble 8, so a wrongly run slot shows
    for (int i = 0; i < 4096; i++) rom[i] = iw(OP_PUT_IMM_TO_MEM, 4'h8, 4'hF);
    rom[0] = iw(OP_SUM_MEM_SKIP_CARRY, 4'h1, 4'h2);
    rom[1] = iw(OP_PUT_IMM_TO_MEM, 4'h3, 4'hF);
    rom[2] = iw(OP_SUM_MEM, 4'h1, 4'h4);
    rom[3] = iw(OP_PUT_IMM_TO_MEM, 4'h5, 4'hA);
    rom[4] = iw(OP_DIFF_MEM_SKIP_BORROW, 4'h1, 4'h6);
    rom[5] = iw(OP_PUT_IMM_TO_MEM, 4'h7, 4'hF);
    rom[6] = iw(OP_COMPARE_MEM_EQ_IMM, 4'h1, 4'h9);
    rom[7] = iw(OP_PUT_IMM_TO_MEM, 4'h8, 4'hF);
    rom[8] = iw(OP_AND_IMM, 4'h5, 4'h6);
    rom[9] = iw(OP_XOR_REG_WITH_MEM, 4'h1, 4'h9);
    rom[10] = iw(OP_SET_FLAG_BITS, 4'h0, 4'hA);
    rom[11] = iw(OP_CLEAR_FLAG_BITS, 4'h0, 4'h2);
    rom[12] = iw(OP_PORT_F_DIRECTION_LATCH, 4'h0, 4'h5);
    rom[13] = iw(OP_PLL_LOAD, 4'h4, 4'h0);
    rom[14] = iw(OP_SEGMENT_DIRECT_WRITE, 4'h1, 4'h1);
    rom[15] = iw(OP_FLAGS_ALL_ONE_SKIP, 4'h0, 4'h6);
    rom[16] = iw(OP_PUT_IMM_TO_MEM, 4'hB, 4'hF);
    rom[17] = 16'hE018;
    rom[24] = 16'hF020;
    rom[25] = 16'hE019;
    rom[32] = iw(OP_RETURN_INT, 4'h0, 4'h0);
    // second program: carry and borrow forms, compares, moves, bank, call and return
    pa = 64;
    put(OP_SUM_MEM_WITH_CARRY, 4'h1, 4'h2);
    put(OP_SUM_CARRY_THEN_SKIP, 4'h1, 4'h6);
    pa++;
    put(OP_SUM_IMM_INTO_MEM, 4'h3, 4'h7);
    put(OP_SUM_IMM_SKIP_CARRY, 4'h3, 4'h9);
    pa++;
    put(OP_SUM_IMM_WITH_CARRY, 4'h7, 4'h2);
    put(OP_SUM_IMM_CARRY_SKIP, 4'h7, 4'hF);
    pa++;
    put(OP_DIFF_MEM_FROM_REG, 4'h1, 4'h9);
    put(OP_DIFF_WITH_BORROW, 4'h1, 4'h9);
    put(OP_DIFF_WITH_BORROW_SKIP, 4'h1, 4'h9);
    pa++;
    put(OP_DIFF_IMM, 4'h5, 4'h3);
    put(OP_DIFF_IMM_WITH_BORROW, 4'h5, 4'h3);
    put(OP_DIFF_IMM_BORROW_SKIP, 4'h5, 4'hB);
    put(OP_DIFF_IMM_SKIP_BORROW, 4'h5, 4'h1);
    pa++;
    put(OP_COMPARE_REG_EQ_MEM, 4'h1, 4'h1);
    pa++;
    put(OP_COMPARE_REG_GE_MEM, 4'h1, 4'h2);
    pa++;
    put(OP_COMPARE_MEM_GE_IMM, 4'h1, 4'hA);
    put(OP_PUT_IMM_TO_MEM, 4'hA, 4'h4);
    put(OP_OR_IMM, 4'hA, 4'h1);
    put(OP_READ_MEM_TO_REG, 4'hA, 4'hB);
    put(OP_WRITE_REG_TO_MEM, 4'h0, 4'hB);
    put(OP_PUT_IMM_TO_MEM, 4'hC, 4'hD);
    put(OP_INDIRECT_DEST_MOVE, 4'h1, 4'hC);
    put(OP_INDIRECT_SRC_MOVE, 4'hE, 4'hC);
    put(OP_CHECK_MEM_BITS_ONE, 4'h1, 4'h9);
    pa++;
    put(OP_CHECK_MEM_BITS_ZERO, 4'h1, 4'h6);
    pa++;
    put(OP_FLAGS_ALL_ZERO_SKIP, 4'h0, 4'h9);
    pa++;
    put(OP_SEGMENT_DECODED_WRITE, 4'h1, 4'h2);
    put(OP_BANK_SELECT, 4'h0, 4'h1);
    put(OP_PUT_IMM_TO_MEM, 4'h0, 4'h7);
    put(OP_BANK_SELECT, 4'h0, 4'h0);
    rom[104] = 16'hF0A0;
    rom[105] = 16'hE069;
    rom[160] = iw(OP_RETURN_SUB, 4'h0, 4'h0);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // reset state and an unmapped read
    bus(1'b0, OFS_PORTF, '0);
    chk("portf reg", 32'h0000_0000, rd);
    bus(1'b0, 11'h3F0, '0);
    chk("unmapped", 32'h0000_0000, rd);
    chk("segments", 32'h0000_0000, 32'(segmentData));
    for (int i = 0; i < 12; i++) bus(1'b1, OFS_MEM + 11'(4 * i), 32'(memIn[i]));
    bus(1'b1, OFS_PC, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 200 && progAddr !== 12'h019; k++) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b0, OFS_PC, '0);
    chk("pc", 32'h0000_0019, rd);
    bus(1'b0, OFS_FLAGS, '0);
    chk("flags", 32'h0000_6804, rd & 32'hFFFF_FFFC);
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, OFS_MEM + 11'(4 * i), '0);
      chk($sformatf("mem %0d", i), 32'(memExp[i]), rd & 32'h0000_000F);
    end
    chk("pll", 32'h0000_0A20, 32'(pllDivider));
    chk("segments", 32'h0000_0480, 32'(segmentData));
    chk("portf dir", 32'h0000_0005, 32'(portFDir));
    chk("int enable", 32'h0000_0001, 32'(intEnable));
    chk("stat1", 32'h0000_0008, 32'(stat1Out));
    // second run from the second program, then read back
    bus(1'b1, OFS_PC, 32'h0000_0040);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 200 && progAddr !== 12'h069; k++) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b0, OFS_PC, '0);
    chk("pc 2", 32'h0000_0069, rd);
    for (int i = 0; i < 15; i++) begin
      bus(1'b0, OFS_MEM + 11'(4 * i), '0);
      chk($sformatf("m%0d", i), 32'(memExp2[i]), 32'(rd[3:0]));
    end
    bus(1'b0, OFS_MEM + 11'h100, '0);
    chk("bank 1 mem", 32'h0000_0007, 32'(rd[3:0]));
    chk("segments 2", 32'h001B_C480, 32'(segmentData));
    results;
  end
endmodule
`default_nettype wire

/* File: test/tmi_core_chk.sv */
// checker: bus timing and decode relations seen at the core's ports
`default_nettype none
module tmi_core_chk
  import tmi_pkg::*;
(
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic [PC_W-1:0]    progAddr,
  input wire logic [15:0]        progWord,
  input wire logic [NIB_W-1:0]   stat2Pins,
  input wire logic [NIB_W-1:0]   stat1Out,
  input wire logic [PLL_W-1:0]   pllDivider,
  input wire logic [SEG_W-1:0]   segmentData,
  input wire logic [NIB_W-1:0]   portFDir,
  input wire logic               intEnable,
  input wire logic [BUS_AW-1:0]  avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // decode helpers; op field is meaningless inside the branch space
  wire logic [5:0] op   = progWord[15:10];
  wire logic       isBr = progWord[15:13] == BR_PREFIX;
  // a landing bus write may load the pc while halted, so it is kept out
  wire logic       wrP  = avs_write && !avs_waitrequest;
  sequence s_jump; isBr && !wrP && !progWord[12] ##1 $changed(progAddr); endsequence
  sequence s_call; isBr && !wrP && progWord[12] ##1 $changed(progAddr); endsequence
  sequence s_plain;
    !isBr && !wrP && op != OP_RETURN_SUB && op != OP_RETURN_INT ##1 $changed(progAddr);
  endsequence
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_back; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_jump; s_jump |-> progAddr == $past(progWord[11:0]); endproperty
  property p_call; s_call |-> progAddr == $past(progWord[11:0]); endproperty
  property p_step; s_plain |-> progAddr == $past(progAddr) + 12'h001; endproperty
  property p_portf;
    $changed(portFDir) && !$past(avs_write) |->
      $past(op) == OP_PORT_F_DIRECTION_LATCH && portFDir == $past(progWord[3:0]);
  endproperty
  property p_stat1;
    $changed(stat1Out) |-> ($past(op) == OP_SET_FLAG_BITS &&
      stat1Out == ($past(stat1Out) | $past(progWord[3:0]))) || ($past(op) ==
      OP_CLEAR_FLAG_BITS && stat1Out == ($past(stat1Out) & ~$past(progWord[3:0])));
  endproperty
  property p_inten; $rose(intEnable) |-> $past(op) == OP_RETURN_INT; endproperty
  property p_pll; $changed(pllDivider) |-> $past(op) == OP_PLL_LOAD || $past(avs_write); endproperty
  property p_seg;
    $changed(segmentData) |-> $past(avs_write) || $past(op) == OP_SEGMENT_DIRECT_WRITE ||
      $past(op) == OP_SEGMENT_DECODED_WRITE;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait state");
  a_wait_back: assert property (p_wait_back) else $error("waitrequest low two cycles");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_call: assert property (p_call) else $error("call target wrong");
  a_step: assert property (p_step) else $error("pc did not step by one");
  a_portf: assert property (p_portf) else $error("direction latch wrong");
  a_stat1: assert property (p_stat1) else $error("status bits wrong");
  a_inten: assert property (p_inten) else $error("interrupt enable rose wrongly");
  a_pll: assert property (p_pll) else $error("pll word changed wrongly");
  a_seg: assert property (p_seg) else $error("segments changed wrongly");
endmodule
bind tmi_core tmi_core_chk u_chk (.clk, .nrst, .progAddr, .progWord, .stat2Pins, .stat1Out,
  .pllDivider, .segmentData, .portFDir, .intEnable, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest);
`default_nettype wire
